/* common/lcdc_pkg.sv */
// Register map, field layout, reset values and timing for the display controller host port
package lcdc_pkg;

  // ==========================================================================
  // Register byte addresses
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_STATUS   = 8'h04;
  localparam logic [7:0] REG_ADDR     = 8'h08;
  localparam logic [7:0] REG_INSTR    = 8'h0C;
  localparam logic [7:0] REG_DATA_IN  = 8'h10;
  localparam logic [7:0] REG_DATA_OUT = 8'h14;
  localparam logic [7:0] REG_SEG_LO   = 8'h18;
  localparam logic [7:0] REG_SEG_HI   = 8'h1C;
  localparam logic [7:0] REG_IRQ_STAT = 8'h20;
  localparam logic [7:0] REG_IRQ_MASK = 8'h24;

  // ==========================================================================
  // Field positions
  localparam int unsigned CTRL_FOUR_BIT = 0;
  localparam int unsigned CTRL_DUTY_LSB = 1;
  localparam int unsigned CTRL_DRIVE_EN = 3;
  localparam int unsigned CTRL_W        = 4;
  localparam int unsigned STAT_BUSY     = 0;
  localparam int unsigned STAT_ADDR_LSB = 8;
  localparam int unsigned IRQ_INSTR     = 0;
  localparam int unsigned IRQ_DATA_WR   = 1;
  localparam int unsigned IRQ_DATA_RD   = 2;
  localparam int unsigned IRQ_LINE      = 3;
  localparam int unsigned IRQ_W         = 4;

  // ==========================================================================
  // Reset values and fixed codes
  localparam logic [CTRL_W-1:0] CTRL_RST     = 4'h0;
  localparam logic [IRQ_W-1:0]  IRQ_MASK_RST = 4'h0;
  localparam logic [6:0]        ADDR_RST     = 7'h00;
  localparam logic [63:0]       SEG_RST      = 64'h0;
  localparam logic [2:0]        HSIZE_WORD   = 3'h2;
  localparam logic [7:0]        OE_NIBBLE    = 8'hF0;
  localparam logic [7:0]        OE_BYTE      = 8'hFF;

  // ==========================================================================
  // Panel geometry and timing
  localparam int unsigned COM_N         = 16;
  localparam int unsigned SEG_N         = 40;
  localparam logic [4:0]  LINES_8       = 5'h08;
  localparam logic [4:0]  LINES_11      = 5'h0B;
  localparam logic [4:0]  LINES_16      = 5'h10;
  localparam int unsigned CORE_CLK_MHZ  = 250;
  localparam int unsigned SHIFT_HALF_NS = 100;
  localparam int unsigned SHIFT_HALF_CYC = (SHIFT_HALF_NS * CORE_CLK_MHZ) / 1000;

  typedef enum logic [1:0] {DUTY_8, DUTY_11, DUTY_16} lcdc_duty_e;
  typedef enum logic [1:0] {DRV_IDLE, DRV_LOW, DRV_HIGH, DRV_LATCH} lcdc_drv_e;

  // Unused duty code falls back to eight lines
  function automatic logic [4:0] lcdc_lines(input logic [1:0] duty);
    lcdc_lines = (duty == DUTY_16) ? LINES_16 : (duty == DUTY_11) ? LINES_11 : LINES_8;
  endfunction : lcdc_lines

endpackage : lcdc_pkg

/* verilog/lcdc_host_port.sv */
// Display controller host port, extension driver link and AHB-Lite register slave
// Notes on behaviour
// - Register select low on a write puts the byte in the instruction register.
// - Register select low on a read returns busy flag and address pointer.
// - Register select high sends writes to the data register; reads return the data output register.
// - Read/write line low means write, high means read.
// - Data bus is driven only during host reads, else released.
// - In 4-bit mode only the upper four data lines carry transfers.
// - Status read puts the busy flag on the top data line.
// - Latch clock tells the extension driver to capture the shifted line.
// - Shift clock advances the extension driver one serial bit.
// - Polarity signal alternates so the drive waveform is AC.
// - Serial output carries one pattern bit per segment, timed by shift clock.
// - At 1/8 duty commons nine to sixteen are never selected.
// - At 1/11 duty commons twelve to sixteen are never selected.
// - Sixteen commons and forty segments; unused commons stay non-selected.
// - In 8-bit mode status read puts the seven-bit address pointer on the lower lines.
`timescale 1ns/1ps
module lcdc_host_port
  import lcdc_pkg::*;
#(
  parameter int unsigned SEG_W      = SEG_N,
  parameter int unsigned SHIFT_HALF = SHIFT_HALF_CYC
) (
  // Clock and reset
  input  wire logic             I_CORE_CLK,
  input  wire logic             I_SYS_RST,
  // AHB-Lite slave
  input  wire logic             I_HSEL,
  input  wire logic [31:0]      I_HADDR,
  input  wire logic [1:0]       I_HTRANS,
  input  wire logic             I_HWRITE,
  input  wire logic [2:0]       I_HSIZE,
  input  wire logic [31:0]      I_HWDATA,
  input  wire logic             I_HREADY,
  output logic                  O_HREADYOUT,
  output logic                  O_HRESP,
  output logic [31:0]           O_HRDATA,
  // Host parallel port
  input  wire logic             I_REGISTER_SELECT,
  input  wire logic             I_READ_WRITE,
  input  wire logic             I_STROBE,
  input  wire logic [7:0]       I_HOST_DATA_BUS,
  output logic [7:0]            O_HOST_DATA_BUS,
  output logic [7:0]            O_HOST_DATA_BUS_OE,
  // Extension driver and panel
  output logic                  O_LINE_LATCH_CLOCK,
  output logic                  O_SEGMENT_SHIFT_CLOCK,
  output logic                  O_POLARITY_ALTERNATE,
  output logic                  O_SERIAL_DATA,
  output logic [COM_N-1:0]      O_COMMON_DRIVE_OUTPUTS,
  output logic [SEG_W-1:0]      O_SEGMENT_DRIVE_OUTPUTS,
  // Interrupt
  output logic                  O_IRQ
);

  if (SEG_W < 1 || SEG_W > 64) begin : g_bad_seg
    $error("SEG_W must lie in 1..64");
  end
  if (SHIFT_HALF < 1 || SHIFT_HALF > 255) begin : g_bad_div
    $error("SHIFT_HALF must lie in 1..255");
  end

  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_SYS_RST);

  function automatic logic hit(input logic [31:0] a, input logic [7:0] off);
    hit = (a[31:8] == 24'h0) && (a[7:0] == off);
  endfunction : hit

  // ==========================================================================
  // AHB-Lite slave: writes zero wait, reads one wait state
  logic              wr_q;
  logic              rd_wait;
  logic [31:0]       addr_q;
  logic [CTRL_W-1:0] ctrl;
  logic              busy;
  logic [6:0]        addr_ptr;
  logic [7:0]        instruction_register;
  logic [7:0]        data_register;
  logic [7:0]        data_out;
  logic [63:0]       seg_pat;
  logic [IRQ_W-1:0]  irq_stat;
  logic [IRQ_W-1:0]  irq_mask;

  wire addr_ok    = I_HSEL & I_HREADY & I_HTRANS[1];
  wire wr_ctrl    = wr_q & hit(addr_q, REG_CTRL);
  wire wr_status  = wr_q & hit(addr_q, REG_STATUS);
  wire wr_addr    = wr_q & hit(addr_q, REG_ADDR);
  wire wr_dout    = wr_q & hit(addr_q, REG_DATA_OUT);
  wire wr_seg_lo  = wr_q & hit(addr_q, REG_SEG_LO);
  wire wr_seg_hi  = wr_q & hit(addr_q, REG_SEG_HI);
  wire wr_istat   = wr_q & hit(addr_q, REG_IRQ_STAT);
  wire wr_imask   = wr_q & hit(addr_q, REG_IRQ_MASK);

  wire [31:0] rd_mux =
    hit(addr_q, REG_CTRL)     ? {28'h0, ctrl} :
    hit(addr_q, REG_STATUS)   ? {17'h0, addr_ptr, 7'h0, busy} :
    hit(addr_q, REG_ADDR)     ? {25'h0, addr_ptr} :
    hit(addr_q, REG_INSTR)    ? {24'h0, instruction_register} :
    hit(addr_q, REG_DATA_IN)  ? {24'h0, data_register} :
    hit(addr_q, REG_DATA_OUT) ? {24'h0, data_out} :
    hit(addr_q, REG_SEG_LO)   ? seg_pat[31:0] :
    hit(addr_q, REG_SEG_HI)   ? seg_pat[63:32] :
    hit(addr_q, REG_IRQ_STAT) ? {28'h0, irq_stat} :
    hit(addr_q, REG_IRQ_MASK) ? {28'h0, irq_mask} : 32'h0;

  always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      wr_q     <= 1'b0;
      rd_wait  <= 1'b0;
      addr_q   <= 32'h0;
      O_HRDATA <= 32'h0;
    end else begin
      // Sub-word writes are answered but not stored
      wr_q    <= addr_ok & I_HWRITE & (I_HSIZE == HSIZE_WORD);
      rd_wait <= addr_ok & ~I_HWRITE;
      if (addr_ok) begin
        addr_q <= I_HADDR;
      end
      if (rd_wait) begin
        O_HRDATA <= rd_mux;
      end
    end
  end

  assign O_HREADYOUT = ~rd_wait;
  assign O_HRESP     = 1'b0;

  // ==========================================================================
  // Host parallel port
  logic       stb_q;
  logic       sel_q;
  logic       rw_q;
  logic       phase;
  logic [7:0] bus_q;
  logic [3:0] hi_nib;
  logic [7:0] rd_byte;

  wire        four_bit  = ctrl[CTRL_FOUR_BIT];
  wire [1:0]  duty      = ctrl[CTRL_DUTY_LSB +: 2];
  wire        drive_en  = ctrl[CTRL_DRIVE_EN];
  wire        stb_rise  = I_STROBE & ~stb_q;
  wire        stb_fall  = ~I_STROBE & stb_q;
  wire        first_nib = ~four_bit | ~phase;
  wire        byte_done = stb_fall & (~four_bit | phase);
  wire [7:0]  wr_byte   = four_bit ? {hi_nib, bus_q[7:4]} : bus_q;
  wire [7:0]  next_rd   = I_REGISTER_SELECT ? data_out : {busy, addr_ptr};
  wire [7:0]  next_dout = ~first_nib ? {rd_byte[3:0], 4'h0} :
                          four_bit ? {next_rd[7:4], 4'h0} : next_rd;
  wire        ev_instr  = byte_done & ~sel_q & ~rw_q;
  wire        ev_dwr    = byte_done & sel_q & ~rw_q;
  wire        ev_drd    = byte_done & sel_q & rw_q;

  always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      stb_q              <= 1'b0;
      sel_q              <= 1'b0;
      rw_q               <= 1'b0;
      bus_q              <= 8'h00;
      phase              <= 1'b0;
      hi_nib             <= 4'h0;
      rd_byte            <= 8'h00;
      O_HOST_DATA_BUS    <= 8'h00;
      O_HOST_DATA_BUS_OE <= 8'h00;
    end else begin
      stb_q <= I_STROBE;
      // Last values seen with the strobe high are what the falling edge acts on
      if (I_STROBE) begin
        sel_q <= I_REGISTER_SELECT;
        rw_q  <= I_READ_WRITE;
        bus_q <= I_HOST_DATA_BUS;
      end
      if (wr_ctrl) begin
        phase <= 1'b0;
      end else if (stb_fall & four_bit) begin
        phase <= ~phase;
      end
      if (stb_fall & four_bit & ~phase & ~rw_q) begin
        hi_nib <= bus_q[7:4];
      end
      if (stb_rise & I_READ_WRITE) begin
        if (first_nib) begin
          rd_byte <= next_rd;
        end
        O_HOST_DATA_BUS    <= next_dout;
        O_HOST_DATA_BUS_OE <= four_bit ? OE_NIBBLE : OE_BYTE;
      end else if (stb_fall) begin
        O_HOST_DATA_BUS_OE <= 8'h00;
      end
    end
  end

  a_status_read: assert property (
    (stb_rise && I_READ_WRITE && !I_REGISTER_SELECT && !four_bit)
      |=> O_HOST_DATA_BUS == {$past(busy), $past(addr_ptr)})
    else $error("status read does not show busy flag and address pointer");
  a_drive_reads: assert property ((O_HOST_DATA_BUS_OE != 8'h00) |-> rw_q)
    else $error("data bus driven outside a host read");
  a_drive_release: assert property (stb_fall |=> O_HOST_DATA_BUS_OE == 8'h00)
    else $error("data bus not released after the strobe");
  a_upper_lanes: assert property ((four_bit && O_HOST_DATA_BUS_OE != 8'h00)
    |-> O_HOST_DATA_BUS_OE == OE_NIBBLE && O_HOST_DATA_BUS[3:0] == 4'h0)
    else $error("lower lines used in 4-bit mode");

  sequence s_first_nibble;
    four_bit && stb_fall && !phase && !wr_ctrl;
  endsequence
  a_nibble_pair: assert property (s_first_nibble |-> !ev_instr && !ev_dwr ##1 phase)
    else $error("byte completed on the upper nibble alone");

  // ==========================================================================
  // Registers written by software, flags set by the host port
  wire [IRQ_W-1:0] irq_ev;

  always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      ctrl                 <= CTRL_RST;
      busy                 <= 1'b0;
      addr_ptr             <= ADDR_RST;
      instruction_register <= 8'h00;
      data_register        <= 8'h00;
      data_out             <= 8'h00;
      seg_pat              <= SEG_RST;
      irq_stat             <= 4'h0;
      irq_mask             <= IRQ_MASK_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl <= I_HWDATA[CTRL_W-1:0];
      end
      // Set wins over a same-cycle clear
      busy <= (busy & ~(wr_status & I_HWDATA[STAT_BUSY])) | ev_instr | ev_dwr;
      if (wr_addr) begin
        addr_ptr <= I_HWDATA[6:0];
      end else if (ev_dwr | ev_drd) begin
        addr_ptr <= addr_ptr + 7'h01;
      end
      if (ev_instr) begin
        instruction_register <= wr_byte;
      end
      if (ev_dwr) begin
        data_register <= wr_byte;
      end
      if (wr_dout) begin
        data_out <= I_HWDATA[7:0];
      end
      if (wr_seg_lo) begin
        seg_pat[31:0] <= I_HWDATA;
      end
      if (wr_seg_hi) begin
        seg_pat[63:32] <= I_HWDATA;
      end
      if (wr_imask) begin
        irq_mask <= I_HWDATA[IRQ_W-1:0];
      end
      irq_stat <= (irq_stat & ~({IRQ_W{wr_istat}} & I_HWDATA[IRQ_W-1:0])) | irq_ev;
    end
  end

  assign O_IRQ = |(irq_stat & irq_mask);

  a_instr_route: assert property (ev_instr
    |=> instruction_register == $past(wr_byte) && data_register == $past(data_register))
    else $error("instruction write not routed to instruction register");
  a_data_route: assert property (ev_dwr
    |=> data_register == $past(wr_byte) && instruction_register == $past(instruction_register))
    else $error("data write not routed to data register");

  // ==========================================================================
  // Extension driver link and common scan
  localparam logic [7:0] DIV_LAST = 8'(SHIFT_HALF - 1);
  localparam logic [5:0] BIT_LAST = 6'(SEG_W - 1);

  lcdc_drv_e        state;
  logic [7:0]       div_cnt;
  logic [5:0]       bit_idx;
  logic [63:0]      shadow;
  logic [4:0]       line;
  logic [COM_N-1:0] next_com;

  wire       tick      = (div_cnt == DIV_LAST);
  wire       last_bit  = (bit_idx == BIT_LAST);
  wire [4:0] lines     = lcdc_lines(duty);
  wire [4:0] next_line = (line >= lines - 5'h01) ? 5'h00 : line + 5'h01;

  // Rows at or above the duty's line count are never selected
  for (genvar gi = 0; gi < COM_N; gi++) begin : g_com
    assign next_com[gi] = (5'(gi) == next_line);
  end

  assign irq_ev = {(state == DRV_LATCH) & tick, ev_drd, ev_dwr, ev_instr};

  always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      state                   <= DRV_IDLE;
      div_cnt                 <= 8'h00;
      bit_idx                 <= 6'h00;
      shadow                  <= SEG_RST;
      line                    <= 5'h00;
      O_SEGMENT_SHIFT_CLOCK   <= 1'b0;
      O_LINE_LATCH_CLOCK      <= 1'b0;
      O_POLARITY_ALTERNATE    <= 1'b0;
      O_SERIAL_DATA           <= 1'b0;
      O_COMMON_DRIVE_OUTPUTS  <= '0;
      O_SEGMENT_DRIVE_OUTPUTS <= '0;
    end else begin
      div_cnt <= tick ? 8'h00 : div_cnt + 8'h01;
      unique case (state)
        DRV_IDLE: begin
          if (tick & drive_en) begin
            // Snapshot so a software update cannot tear a line
            shadow        <= seg_pat;
            bit_idx       <= 6'h00;
            O_SERIAL_DATA <= seg_pat[0];
            state         <= DRV_LOW;
          end else if (!drive_en) begin
            O_COMMON_DRIVE_OUTPUTS <= '0;
          end
        end
        DRV_LOW: begin
          if (tick) begin
            O_SEGMENT_SHIFT_CLOCK <= 1'b1;
            state                 <= DRV_HIGH;
          end
        end
        DRV_HIGH: begin
          if (tick) begin
            O_SEGMENT_SHIFT_CLOCK <= 1'b0;
            if (last_bit) begin
              O_LINE_LATCH_CLOCK <= 1'b1;
              state              <= DRV_LATCH;
            end else begin
              bit_idx       <= bit_idx + 6'h01;
              O_SERIAL_DATA <= shadow[bit_idx + 6'h01];
              state         <= DRV_LOW;
            end
          end
        end
        DRV_LATCH: begin
          if (tick) begin
            O_LINE_LATCH_CLOCK      <= 1'b0;
            O_SEGMENT_DRIVE_OUTPUTS <= shadow[SEG_W-1:0];
            O_COMMON_DRIVE_OUTPUTS  <= next_com;
            line                    <= next_line;
            O_POLARITY_ALTERNATE    <= ~O_POLARITY_ALTERNATE;
            state                   <= DRV_IDLE;
          end
        end
      endcase
    end
  end

  sequence s_last_shift;
    state == DRV_HIGH && tick && last_bit;
  endsequence
  a_line_latch: assert property (s_last_shift
    |=> O_LINE_LATCH_CLOCK && !O_SEGMENT_SHIFT_CLOCK)
    else $error("latch clock missing after last segment bit");
  a_shift_stable: assert property ($rose(O_SEGMENT_SHIFT_CLOCK) |-> $stable(O_SERIAL_DATA))
    else $error("serial data changed on shift clock edge");
  a_polarity_flip: assert property ($fell(O_LINE_LATCH_CLOCK)
    |-> O_POLARITY_ALTERNATE != $past(O_POLARITY_ALTERNATE))
    else $error("polarity did not alternate at line latch");
  a_unused_commons: assert property ((state == DRV_LATCH && tick)
    |=> (O_COMMON_DRIVE_OUTPUTS >> $past(lines)) == 16'h0 && $onehot(O_COMMON_DRIVE_OUTPUTS))
    else $error("common outside duty selected");

endmodule : lcdc_host_port

/* test/lcdc_host_model.sv */
// Host processor model for the display controller parallel port
`timescale 1ns/1ps
module lcdc_host_model (
  // Clock
  input  wire logic       i_clk,
  // Device read drive
  input  wire logic [7:0] i_dev_data,
  input  wire logic [7:0] i_dev_oe,
  // Host selects, strobe and resolved bus
  output logic            o_rs,
  output logic            o_rw,
  output logic            o_stb,
  output logic [7:0]      o_bus
);
  // ==========================================================================
  // Bus resolution
  logic       hoe = 1'b0;
  logic [7:0] hd = 8'h00;
  logic [7:0] junk = 8'hA5;
  initial begin
    o_rs = 1'b0;
    o_rw = 1'b1;
    o_stb = 1'b0;
  end
  // Undriven lines wander so a stale level never passes for read data
  always @(posedge i_clk) junk <= ~junk;
  assign o_bus = (i_dev_oe & i_dev_data) | (~i_dev_oe & (hoe ? hd : junk));

  // ==========================================================================
  // Transfers
  task automatic xfer(input logic rs, input logic rw, input logic [7:0] d,
                      output logic [7:0] q, output logic [7:0] oe);
    @(posedge i_clk);
    o_rs <= rs;
    o_rw <= rw;
    hd <= d;
    hoe <= ~rw;
    @(posedge i_clk);
    o_stb <= 1'b1;
    repeat (3) @(posedge i_clk);
    @(negedge i_clk);
    q = o_bus;
    oe = i_dev_oe;
    @(posedge i_clk);
    o_stb <= 1'b0;
    repeat (3) @(posedge i_clk);
    hoe <= 1'b0;
  endtask : xfer

  task automatic nib(input logic rs, input logic rw, input logic [7:0] d,
                     output logic [7:0] q, output logic [7:0] oe);
    logic [7:0] q1;
    logic [7:0] o2;
    // Lower lines carry garbage that the device has to ignore
    xfer(rs, rw, {d[7:4], ~d[3:0]}, q1, oe);
    xfer(rs, rw, {d[3:0], d[7:4]}, q, o2);
    q = {q1[7:4], q[7:4]};
  endtask : nib
endmodule : lcdc_host_model

/* test/lcdc_host_port_bench.sv */
// Self-checking bench for the display controller host port and driver link
`timescale 1ns/1ps
module lcdc_host_port_bench
  import lcdc_pkg::*;
;
  // ==========================================================================
  // Signals
  localparam logic [39:0] PAT = 40'hB7_8421F0E1;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        hrdy, hresp, rs, rw, stb, lclk, sclk, pol, ser, irq, pol_q;
  logic        sclk_q = 1'b0;
  logic        lclk_q = 1'b0;
  logic [31:0] hrdata, x;
  logic [7:0]  bus, dout, doe, q, o;
  logic [15:0] com, rows;
  logic [39:0] seg, cap;
  int          mismatches = 0;
  int          comparisons = 0;
  int          nsh = 0;
  int          nlat = 0;

  always #2 clk = ~clk;

  lcdc_host_port #(.SHIFT_HALF(2)) i_lcdc_host_port (
    .I_CORE_CLK(clk), .I_SYS_RST(rst), .I_HSEL(1'b1), .I_HADDR(haddr), .I_HTRANS(htrans),
    .I_HWRITE(hwrite), .I_HSIZE(HSIZE_WORD), .I_HWDATA(hwdata), .I_HREADY(hrdy),
    .O_HREADYOUT(hrdy), .O_HRESP(hresp), .O_HRDATA(hrdata),
    .I_REGISTER_SELECT(rs), .I_READ_WRITE(rw), .I_STROBE(stb), .I_HOST_DATA_BUS(bus),
    .O_HOST_DATA_BUS(dout), .O_HOST_DATA_BUS_OE(doe), .O_LINE_LATCH_CLOCK(lclk),
    .O_SEGMENT_SHIFT_CLOCK(sclk), .O_POLARITY_ALTERNATE(pol), .O_SERIAL_DATA(ser),
    .O_COMMON_DRIVE_OUTPUTS(com), .O_SEGMENT_DRIVE_OUTPUTS(seg), .O_IRQ(irq));

  lcdc_host_model i_lcdc_host_model (.i_clk(clk), .i_dev_data(dout), .i_dev_oe(doe),
    .o_rs(rs), .o_rw(rw), .o_stb(stb), .o_bus(bus));

  // ==========================================================================
  // Checking and bus tasks
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task wrap_up;
    if (mismatches == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up

  task tmo;
    mismatches++;
    wrap_up();
  endtask : tmo

  // Ready is judged mid-cycle, where it equals what the next rising edge samples
  task automatic wait_rdy(output logic [31:0] d);
    int n;
    for (n = 0; n < 20; n++) begin
      @(negedge clk);
      if (hrdy === 1'b1) break;
    end
    d = hrdata;
    @(posedge clk);
    if (n == 20) tmo();
  endtask : wait_rdy

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy(r);
    htrans <= 2'h0;
    hwrite <= 1'b0;
    hwdata <= d;
    wait_rdy(r);
  endtask : ahb

  // ==========================================================================
  // Driver link monitor, sampled mid-cycle so no output is read as it launches
  always @(negedge clk) begin
    sclk_q <= sclk;
    lclk_q <= lclk;
    if (sclk && !sclk_q) begin
      cap <= {ser, cap[39:1]};
      nsh <= nsh + 1;
    end
    if (lclk && !lclk_q) begin
      chk(nsh, 40);
      chk(cap, PAT);
      if (nlat > 0) chk(pol, !pol_q);
      pol_q <= pol;
      nsh <= 0;
      nlat <= nlat + 1;
    end
  end

  // ==========================================================================
  // Scenarios
  task t_reset;
    ahb(1'b1, 8'h30, 32'hFFFFFFFF, x);
    ahb(1'b0, 8'h30, 32'h0, x);
    chk(x, 32'h0);
    chk(hresp, 1'b0);
    ahb(1'b0, REG_CTRL, 32'h0, x);
    chk(x, CTRL_RST);
    ahb(1'b0, REG_IRQ_MASK, 32'h0, x);
    chk(x, IRQ_MASK_RST);
  endtask : t_reset

  task t_instr;
    i_lcdc_host_model.xfer(1'b0, 1'b0, 8'h3C, q, o);
    ahb(1'b0, REG_INSTR, 32'h0, x);
    chk(x, 32'h3C);
    ahb(1'b0, REG_IRQ_STAT, 32'h0, x);
    chk(x, 32'h1);
    i_lcdc_host_model.xfer(1'b0, 1'b1, 8'h00, q, o);
    chk(q, 8'h80);
    chk(o, OE_BYTE);
    chk(doe, 8'h00);
  endtask : t_instr

  task t_data;
    int n;
    ahb(1'b1, REG_DATA_OUT, 32'hC3, x);
    i_lcdc_host_model.xfer(1'b1, 1'b0, 8'h5A, q, o);
    ahb(1'b0, REG_DATA_IN, 32'h0, x);
    chk(x, 32'h5A);
    i_lcdc_host_model.xfer(1'b1, 1'b1, 8'h00, q, o);
    chk(q, 8'hC3);
    ahb(1'b1, REG_STATUS, 32'h1, x);
    for (n = 0; n < 8; n++) begin
      i_lcdc_host_model.xfer(1'b0, 1'b1, 8'h00, q, o);
      if (q[7] === 1'b0) break;
    end
    chk(q, 8'h02);
    ahb(1'b1, REG_ADDR, 32'h55, x);
    i_lcdc_host_model.xfer(1'b0, 1'b1, 8'h00, q, o);
    chk(q, 8'h55);
  endtask : t_data

  task t_nibble;
    ahb(1'b1, REG_CTRL, 32'h1, x);
    i_lcdc_host_model.nib(1'b0, 1'b0, 8'hA7, q, o);
    ahb(1'b0, REG_INSTR, 32'h0, x);
    chk(x, 32'hA7);
    i_lcdc_host_model.nib(1'b0, 1'b1, 8'h00, q, o);
    chk(q, 8'hD5);
    chk(o, OE_NIBBLE);
    ahb(1'b1, REG_CTRL, 32'h0, x);
  endtask : t_nibble

  task t_irq;
    chk(irq, 1'b0);
    ahb(1'b1, REG_IRQ_MASK, 32'h1, x);
    @(negedge clk);
    chk(irq, 1'b1);
    ahb(1'b1, REG_IRQ_STAT, 32'h1, x);
    @(negedge clk);
    chk(irq, 1'b0);
    ahb(1'b0, REG_IRQ_STAT, 32'h0, x);
    chk(x, 32'h6);
    ahb(1'b1, REG_IRQ_MASK, 32'h0, x);
  endtask : t_irq

  task t_link;
    int n;
    int n0;
    logic [4:0] ln;
    ahb(1'b1, REG_SEG_LO, PAT[31:0], x);
    ahb(1'b1, REG_SEG_HI, {24'h0, PAT[39:32]}, x);
    for (int i = 0; i < 4; i++) begin
      // Spare duty code must scan like 1/8
      ln = (i == 1) ? LINES_11 : (i == 2) ? LINES_16 : LINES_8;
      ahb(1'b1, REG_CTRL, {28'h0, 1'b1, 2'(i), 1'b0}, x);
      rows = 16'h0;
      n0 = nlat;
      for (n = 0; n < 9000 && nlat < n0 + ln + 1; n++) begin
        @(negedge clk);
        rows = rows | com;
      end
      if (n == 9000) tmo();
      chk(rows, (17'h1 << ln) - 17'h1);
      chk(seg, PAT);
      ahb(1'b1, REG_CTRL, 32'h0, x);
      for (n = 0; n < 400 && com !== 16'h0; n++) @(posedge clk);
      if (n == 400) tmo();
    end
    ahb(1'b0, REG_IRQ_STAT, 32'h0, x);
    chk(x, 32'hE);
  endtask : t_link

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_instr();
    t_data();
    t_nibble();
    t_irq();
    t_link();
    wrap_up();
  end
endmodule : lcdc_host_port_bench
